// ### interval_timer_cfg.svh
`ifndef INTERVAL_TIMER_CFG_SVH
`define INTERVAL_TIMER_CFG_SVH

// register byte offsets on the apb word map
`define OFS_RUN_CONTROL     12'h000
`define OFS_CLOCK_SELECT    12'h004
`define OFS_COMPARE         12'h008
`define OFS_COUNTER         12'h00c

// reset values
`define RST_RUN_CONTROL     8'h00
`define RST_CLOCK_SELECT    8'h11
`define RST_COUNTER         16'h0000

// field positions in timer_run_control
`define BIT_RUN_ENABLE      7
`define BIT_WIDTH_SELECT    4
// upper nibble of count_clock_select serves this timer
`define SEL_HI              7
`define SEL_LO              4

// count clock source codes (upper nibble of count_clock_select)
`define SEL_DIV_MAX         4'h8
`define SEL_EXT_RISE        4'he
`define SEL_EXT_FALL        4'hf
// smallest prescale divisor; the select code shifts it up by powers of two
`define DIV_BASE            11'h004

`define BYTE_ZERO           8'h00
`define HALF_ZERO           16'h0000
`define WORD_ZERO           32'h0000_0000

`endif

// ### interval_timer_pkg.sv
package interval_timer_pkg;

    typedef logic [15:0] count_t;

    typedef enum logic [1:0] {
        SRC_DIV,
        SRC_EXT_RISE,
        SRC_EXT_FALL,
        SRC_NONE
    } clk_src_e;

endpackage

// ### count_tick_gen.sv
`timescale 1ns/100ps
`include "interval_timer_cfg.svh"

module count_tick_gen
    import interval_timer_pkg::*;
#(
    parameter int PRE_W = 10
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [3:0] sel,
    input  wire logic       ext_count_in,
    output logic            tick
);

    logic [PRE_W-1:0] pre_q;
    logic [PRE_W-1:0] pre_d;
    logic             ext_prev_q;
    logic             ext_prev_d;
    logic             tick_q;
    logic             tick_d;
    logic [PRE_W:0]   span;
    logic [PRE_W-1:0] mask;
    clk_src_e         src;

    always_comb begin
        pre_d      = pre_q + 1'b1;
        ext_prev_d = ext_count_in;
        span       = (PRE_W+1)'(`DIV_BASE) << sel;
        mask       = PRE_W'(span - 1'b1);
        if (sel <= `SEL_DIV_MAX) begin
            src = SRC_DIV;
        end else if (sel == `SEL_EXT_RISE) begin
            src = SRC_EXT_RISE;
        end else if (sel == `SEL_EXT_FALL) begin
            src = SRC_EXT_FALL;
        end else begin
            src = SRC_NONE;
        end
        // free-running divider: one pulse when the selected low bits all read one
        case (src)
            SRC_DIV:      tick_d = &(pre_q | ~mask);           // [RQ1] [RQ12]
            SRC_EXT_RISE: tick_d = ext_count_in & ~ext_prev_q; // [RQ1]
            SRC_EXT_FALL: tick_d = ~ext_count_in & ext_prev_q; // [RQ1]
            default:      tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_q      <= '0;
            ext_prev_q <= 1'b0;
            tick_q     <= 1'b0;
        end else begin
            pre_q      <= pre_d;
            ext_prev_q <= ext_prev_d;
            tick_q     <= tick_d;
        end
    end

    assign tick = tick_q;

    property p_div4_period;
        @(posedge clk_sys) disable iff (rst)
        (tick_q && sel == 4'h0) ##1 (sel == 4'h0) [*4] |-> tick_q;
    endproperty
    a_div4_period: assert property (p_div4_period) // [RQ12]
        else $error("divide-by-4 count clock period wrong");

endmodule

// ### interval_timer.sv
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "interval_timer_cfg.svh"

// Summary of operation
// RQ1 - count clock is a prescaled system clock or an edge-detected input
// RQ2 - run-control upper nibble drives this timer; register resets to zero
// RQ3 - clock-select upper nibble picks count clock; register resets to 11 hex
// RQ4 - width select bit 4: zero gives 8-bit, one gives 16-bit counting
// RQ5 - reset clears the counter and leaves counting stopped
// RQ6 - setting run enable clears counter on next count clock, then counts up
// RQ7 - clearing run enable zeroes the counter at once and stops matches
// RQ8 - rewriting run enable as one leaves counting undisturbed
// RQ9 - on match the count holds until the next count clock, then clears
// RQ10 - restart after stop counts from zero at the next count clock
// RQ11 - a match raises the compare interrupt; auto clear gives repeating interval
// RQ12 - interval is compare plus one times divisor; divisors 4 to 1024
// RQ13 - stopping while matched still raises the compare interrupt
// RQ14 - software stops the timer before changing the clock select
// RQ15 - the periodic compare event also serves as serial baud clock
// RQ16 - matches are only detected on counter increments
// RQ17 - no match detection in the cycle the compare register is written
// RQ18 - compare register is not initialised by reset
// RQ19 - compare interrupt is a one-cycle pulse per match
// RQ20 - in 8-bit mode only the low bytes count and compare

module interval_timer
    import interval_timer_pkg::*;
#(
    parameter int PRE_W = 10
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_count_in,
    output logic             compare_irq,
    output logic             baud_tick
);

    // apb slave
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;
    logic        setup;
    logic        acc_wr;
    logic        wr_ctl;
    logic        wr_sel;
    logic        wr_cmp;
    logic        mapped;

    // registers and counter state
    logic [7:0]  run_ctl_q;
    logic [7:0]  run_ctl_d;
    logic [7:0]  clk_sel_q;
    logic [7:0]  clk_sel_d;
    count_t      cmp_q;
    count_t      cmp_d;
    count_t      cnt_q;
    count_t      cnt_d;
    logic        pend_q;
    logic        pend_d;
    logic        hold_q;
    logic        hold_d;
    logic        irq_q;
    logic        irq_d;
    logic        baud_q;
    logic        baud_d;

    logic        tick;
    logic        run_now;
    logic        run_next;
    logic        wide_now;
    logic        wide_next;
    logic        start;
    count_t      inc_val;
    count_t      cmp_eff;
    logic        match;

    count_tick_gen #(
        .PRE_W        (PRE_W)
    ) u_tick (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .sel          (clk_sel_q[`SEL_HI:`SEL_LO]), // [RQ3]
        .ext_count_in (ext_count_in),
        .tick         (tick)
    );

    always_comb begin
        setup  = psel & ~penable;
        acc_wr = psel & penable & pready_q & pwrite;
        mapped = (paddr == `OFS_RUN_CONTROL) || (paddr == `OFS_CLOCK_SELECT) ||
                 (paddr == `OFS_COMPARE) || (paddr == `OFS_COUNTER);
        wr_ctl = acc_wr & (paddr == `OFS_RUN_CONTROL);
        wr_sel = acc_wr & (paddr == `OFS_CLOCK_SELECT);
        wr_cmp = acc_wr & (paddr == `OFS_COMPARE);

        // answer is ready in the first access cycle; read data sampled in setup
        pready_d  = setup;
        pslverr_d = setup & ~mapped;
        prdata_d  = prdata_q;
        if (setup) begin
            case (paddr)
                `OFS_RUN_CONTROL:  prdata_d = {24'h00_0000, run_ctl_q};
                `OFS_CLOCK_SELECT: prdata_d = {24'h00_0000, clk_sel_q};
                `OFS_COMPARE:      prdata_d = {16'h0000, cmp_q};
                `OFS_COUNTER:      prdata_d = {16'h0000, cnt_q};
                default:           prdata_d = `WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata_q  <= `WORD_ZERO;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // register file; lower nibbles belong to the sibling timer and are only stored
    always_comb begin
        run_ctl_d = wr_ctl ? pwdata[7:0] : run_ctl_q; // [RQ2]
        // changing the source while running is left to software to avoid
        clk_sel_d = wr_sel ? pwdata[7:0] : clk_sel_q; // [RQ3] [RQ14]
        cmp_d     = wr_cmp ? pwdata[15:0] : cmp_q;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            run_ctl_q <= `RST_RUN_CONTROL;  // [RQ2]
            clk_sel_q <= `RST_CLOCK_SELECT; // [RQ3]
        end else begin
            run_ctl_q <= run_ctl_d;
            clk_sel_q <= clk_sel_d;
        end
    end

    // no reset on purpose: contents stay undefined until software loads them
    always_ff @(posedge clk_sys) begin
        cmp_q <= cmp_d; // [RQ18]
    end

    // counter, start pending, match hold and compare pulse
    always_comb begin
        run_now   = run_ctl_q[`BIT_RUN_ENABLE];
        run_next  = run_ctl_d[`BIT_RUN_ENABLE];
        wide_now  = run_ctl_q[`BIT_WIDTH_SELECT];  // [RQ4]
        wide_next = run_ctl_d[`BIT_WIDTH_SELECT];
        start     = ~run_now & run_next;
        // a rewrite of one while running is not a start
        inc_val   = wide_now ? cnt_q + 16'h0001
                             : {`BYTE_ZERO, cnt_q[7:0] + 8'h01}; // [RQ4] [RQ20]
        cmp_eff   = wide_now ? cmp_q : {`BYTE_ZERO, cmp_q[7:0]}; // [RQ20]
        // compare written this cycle: its match is not seen
        match     = (inc_val == cmp_eff) & ~wr_cmp; // [RQ16] [RQ17]

        cnt_d  = cnt_q;
        pend_d = pend_q | start; // [RQ8]
        hold_d = hold_q;
        irq_d  = 1'b0;           // [RQ19]
        if (run_now && tick) begin
            if (pend_q || hold_q) begin
                cnt_d  = `HALF_ZERO; // [RQ6] [RQ9] [RQ10]
                pend_d = 1'b0;
                hold_d = 1'b0;
            end else begin
                cnt_d = inc_val;     // [RQ16]
                if (match) begin
                    irq_d  = 1'b1;   // [RQ11] [RQ13]
                    hold_d = 1'b1;   // [RQ9]
                end
            end
        end
        // the stop wins over counting, yet a match caught this cycle still pulses
        if (!run_next) begin
            cnt_d  = `HALF_ZERO; // [RQ7]
            pend_d = 1'b0;
            hold_d = 1'b0;
        end
        if (!wide_next) begin
            cnt_d[15:8] = `BYTE_ZERO; // [RQ20]
        end
        baud_d = irq_d; // [RQ15]
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q  <= `RST_COUNTER; // [RQ5]
            pend_q <= 1'b0;
            hold_q <= 1'b0;
            irq_q  <= 1'b0;
            baud_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            pend_q <= pend_d;
            hold_q <= hold_d;
            irq_q  <= irq_d;
            baud_q <= baud_d;
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign compare_irq = irq_q;
    assign baud_tick   = baud_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_stop_zero;
        !run_now |-> cnt_q == `HALF_ZERO;
    endproperty
    a_stop_zero: assert property (p_stop_zero) // [RQ7]
        else $error("counter not zero while stopped");

    property p_start_clear;
        (pend_q && tick && run_now && run_next) |=> cnt_q == `HALF_ZERO;
    endproperty
    a_start_clear: assert property (p_start_clear) // [RQ6]
        else $error("first count clock after start did not clear counter");

    property p_hold_clear;
        (hold_q && tick && run_now) |=> (cnt_q == `HALF_ZERO) && !hold_q;
    endproperty
    a_hold_clear: assert property (p_hold_clear) // [RQ9]
        else $error("matched count not cleared on next count clock");

    property p_hold_keep;
        (hold_q && !tick && run_now && run_next && wide_now == wide_next)
            |=> $stable(cnt_q);
    endproperty
    a_hold_keep: assert property (p_hold_keep) // [RQ9]
        else $error("matched count changed before next count clock");

    property p_match_irq;
        (run_now && tick && !pend_q && !hold_q && inc_val == cmp_eff && !wr_cmp)
            |=> compare_irq && baud_tick;
    endproperty
    a_match_irq: assert property (p_match_irq) // [RQ11]
        else $error("match did not raise the compare interrupt");

    property p_irq_needs_tick;
        !tick |=> !compare_irq;
    endproperty
    a_irq_needs_tick: assert property (p_irq_needs_tick) // [RQ16]
        else $error("compare interrupt without an increment");

    property p_cmp_write_blind;
        wr_cmp |=> !compare_irq;
    endproperty
    a_cmp_write_blind: assert property (p_cmp_write_blind) // [RQ17]
        else $error("match detected while compare written");

    property p_irq_pulse;
        compare_irq |=> !compare_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) // [RQ19]
        else $error("compare interrupt longer than one cycle");

    property p_narrow;
        !wide_now |-> cnt_q[15:8] == `BYTE_ZERO;
    endproperty
    a_narrow: assert property (p_narrow) // [RQ20]
        else $error("upper counter byte set in 8-bit mode");

    property p_rewrite_run;
        (run_now && wr_ctl && pwdata[`BIT_RUN_ENABLE] && !tick &&
         wide_now == wide_next) |=> $stable(cnt_q);
    endproperty
    a_rewrite_run: assert property (p_rewrite_run) // [RQ8]
        else $error("rewriting run enable disturbed the count");

    // register writes land at the access edge
    property p_run_ctl_write;
        wr_ctl |=> run_ctl_q == $past(pwdata[7:0]);
    endproperty
    a_run_ctl_write: assert property (p_run_ctl_write) // [RQ2]
        else $error("run control write did not land");

    property p_clk_sel_write;
        wr_sel |=> clk_sel_q == $past(pwdata[7:0]);
    endproperty
    a_clk_sel_write: assert property (p_clk_sel_write) // [RQ3]
        else $error("clock select write did not land");

    // a start only arms the clear; the count clock does the rest
    property p_start_arm;
        start |=> pend_q;
    endproperty
    a_start_arm: assert property (p_start_arm) // [RQ6]
        else $error("start did not arm the first clear");

    property p_pend_done;
        (pend_q && tick && run_now) |=> !pend_q;
    endproperty
    a_pend_done: assert property (p_pend_done) // [RQ10]
        else $error("start clear still pending after a count clock");

    property p_stopped_quiet;
        !run_now |=> !compare_irq;
    endproperty
    a_stopped_quiet: assert property (p_stopped_quiet) // [RQ7]
        else $error("compare interrupt while stopped");

    property p_stop_hit_irq;
        (run_now && !run_next && tick && !pend_q && !hold_q && inc_val == cmp_eff &&
         !wr_cmp) |=> compare_irq;
    endproperty
    a_stop_hit_irq: assert property (p_stop_hit_irq) // [RQ13]
        else $error("match at stop lost its interrupt");

    property p_wide_step;
        (run_now && run_next && wide_now && wide_next && tick && !pend_q && !hold_q)
            |=> cnt_q == $past(cnt_q) + 16'h0001;
    endproperty
    a_wide_step: assert property (p_wide_step) // [RQ4]
        else $error("16-bit count clock did not step by one");

    property p_narrow_wrap;
        (run_now && run_next && !wide_now && !wide_next && tick && !pend_q && !hold_q &&
         (&cnt_q[7:0])) |=> cnt_q == `HALF_ZERO;
    endproperty
    a_narrow_wrap: assert property (p_narrow_wrap) // [RQ20]
        else $error("8-bit count did not wrap within the low byte");

    c_irq:       cover property (compare_irq);
    c_restart:   cover property (start ##[1:40] (tick && pend_q));
    c_stop_hit:  cover property (irq_d && !run_next);
    c_wide_irq:  cover property (wide_now && compare_irq);
    c_cmp_blind: cover property (wr_cmp && run_now && tick);

endmodule

// ### interval_timer_8_16_test.sv
`timescale 1ns/100ps
`include "interval_timer_cfg.svh"

module interval_timer_8_16_test;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_count_in = 1'b0;
    logic        compare_irq;
    logic        baud_tick;
    logic [31:0] rd;
    logic [31:0] c1;
    logic        er;
    int          fails = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          last_t = 0;
    int          per = 0;
    int          irq_n = 0;
    int          n0;

    interval_timer dut_u (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .ext_count_in (ext_count_in),
        .compare_irq  (compare_irq),
        .baud_tick    (baud_tick)
    );

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task report_and_stop;
        $display("checks=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // period between compare pulses, and the baud event must track the irq
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (baud_tick !== compare_irq) chk({31'h0, baud_tick}, {31'h0, compare_irq});
        if (compare_irq === 1'b1) begin
            per <= cyc - last_t;
            last_t <= cyc;
            irq_n <= irq_n + 1;
        end
        if (cyc > 60000) begin
            fails++;
            report_and_stop();
        end
    end

    // waits for pready however long it takes; only the cycle ceiling ends a hang
    task apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task wait_c(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // clock select is only changed while stopped
    task interval(input logic [3:0] s, input logic w, input logic [15:0] cmp, input int exp);
        wr(`OFS_RUN_CONTROL, 32'h0);
        wr(`OFS_CLOCK_SELECT, {24'h0, s, 4'h1});
        wr(`OFS_COMPARE, {16'h0, cmp});
        wr(`OFS_RUN_CONTROL, {24'h0, 1'b1, 2'b00, w, 4'h0});
        wait_c(3 * exp + 40);
        chk(per, exp);
    endtask

    task ext_pulses(input int k);
        repeat (k) begin
            ext_count_in <= 1'b1;
            wait_c(4);
            ext_count_in <= 1'b0;
            wait_c(4);
        end
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rchk(`OFS_RUN_CONTROL, 32'h0000_0000);
        rchk(`OFS_CLOCK_SELECT, 32'h0000_0011);
        rchk(`OFS_COUNTER, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, er}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        wr(`OFS_COUNTER, 32'h0000_0055);
        rchk(`OFS_COUNTER, 32'h0000_0000);
        for (int s = 0; s <= 8; s++) begin
            interval(s[3:0], 1'b0, 16'h0001, 2 * (4 << s));
        end
        rchk(`OFS_CLOCK_SELECT, 32'h0000_0081);
        interval(4'h0, 1'b0, 16'h0103, 16);
        rchk(`OFS_RUN_CONTROL, 32'h0000_0080);
        interval(4'h0, 1'b1, 16'h0103, 1040);
        rchk(`OFS_COMPARE, 32'h0000_0103);
        wr(`OFS_RUN_CONTROL, 32'h0);
        rchk(`OFS_COUNTER, 32'h0000_0000);
        n0 = irq_n;
        wait_c(1100);
        chk(irq_n, n0);
        // slow divisor keeps the count still across the next few accesses
        wr(`OFS_CLOCK_SELECT, 32'h0000_0081);
        wr(`OFS_COMPARE, 32'h0000_00ff);
        wr(`OFS_RUN_CONTROL, 32'h0000_0080);
        wait_c(3200);
        apb(1'b0, `OFS_COUNTER, 32'h0);
        c1 = rd;
        wr(`OFS_RUN_CONTROL, 32'h0000_0080);
        // two or more count clocks later a cleared count could not reach c1 + 2
        wait_c(2100);
        apb(1'b0, `OFS_COUNTER, 32'h0);
        chk({31'h0, (rd >= c1 + 32'h2 && c1 >= 32'h2)}, 32'h0000_0001);
        n0 = irq_n;
        wr(`OFS_COMPARE, rd);
        wait_c(500);
        chk(irq_n, n0);
        for (int e = 14; e <= 15; e++) begin
            wr(`OFS_RUN_CONTROL, 32'h0);
            wr(`OFS_CLOCK_SELECT, {24'h0, e[3:0], 4'h1});
            wr(`OFS_COMPARE, 32'h0000_00ff);
            wr(`OFS_RUN_CONTROL, 32'h0000_0080);
            ext_pulses(4);
            rchk(`OFS_COUNTER, 32'h0000_0003);
        end
        wr(`OFS_RUN_CONTROL, 32'h0);
        rchk(`OFS_COUNTER, 32'h0000_0000);
        wr(`OFS_RUN_CONTROL, 32'h0000_0080);
        ext_pulses(1);
        rchk(`OFS_COUNTER, 32'h0000_0000);
        ext_pulses(1);
        rchk(`OFS_COUNTER, 32'h0000_0001);
        // an unused select code gives no count clock at all
        wr(`OFS_RUN_CONTROL, 32'h0);
        wr(`OFS_CLOCK_SELECT, 32'h0000_0091);
        wr(`OFS_RUN_CONTROL, 32'h0000_0080);
        wait_c(100);
        rchk(`OFS_COUNTER, 32'h0000_0000);
        report_and_stop();
    end
endmodule
